// *** core/tio_top.sv ***
// Notes on behaviour
// - Each output turns on after its on-delay.
// - Each output turns off after its off-delay.
// - Delays 0-100 s in tenths, default zero.
// - Six logic outputs from two selected sources.
// - Operator code: 00 AND, 01 OR, 02 XOR.
// - Logic outputs never offered as sources.
// - Eight input filters: 0-200 x 2ms, default 1.
// - Forward-run input filtered the same way.
// - Multi-step selection latched after 0-200 x 10 ms.
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/1ns
`include "tio_cfg.svh"

module tio_top #(
    parameter int TICK_CYCLES = `TIO_BASE_TICK_CYCLES
) (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic reset_n_in,
    // APB slave.
    input wire tio_pkg::tio_apb_req_t apb_req_in,
    output logic pready_out,
    output logic pslverr_out,
    output logic [31:0] prdata_out,
    // Field terminals and drive status.
    input wire logic [tio_pkg::TIO_NUM_IN-1:0] terminal_raw_in,
    input wire logic [tio_pkg::TIO_NUM_OUT-1:0] out_source_in,
    input wire logic [tio_pkg::TIO_NUM_SRC-1:0] status_source_in,
    // Results.
    output logic [tio_pkg::TIO_NUM_IN-1:0] terminal_filtered_out,
    output logic [tio_pkg::TIO_NUM_OUT-1:0] terminal_drive_out,
    output logic [tio_pkg::TIO_NUM_LOG-1:0] combined_logic_out,
    output logic [7:0] multistep_select_out
);
    import tio_pkg::*;

    // ****************************************************************
    // Time base
    // ****************************************************************
    // Every wait counts this one free-running 2 ms tick, so a wait may end up
    // to one tick early; coarser shared ticks would cost a whole step instead.
    logic [31:0] base_cnt_reg;
    logic tick_base;

    assign tick_base = (base_cnt_reg == 32'(TICK_CYCLES - 1));

    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in || tick_base)
            base_cnt_reg <= 32'h0000_0000;
        else
            base_cnt_reg <= base_cnt_reg + 32'h0000_0001;
    end

    // ****************************************************************
    // Register file
    // ****************************************************************
    tio_delay_t delay_reg [TIO_NUM_OUT];
    tio_logic_cfg_t logic_cfg_reg [TIO_NUM_LOG];
    logic [7:0] filt_time_reg [TIO_NUM_IN];
    logic [7:0] settle_time_reg;
    logic [5:0] idx;
    logic wr_en, mapped;
    logic [31:0] rd_next;
    logic [9:0] wr_on, wr_off;
    logic [7:0] wr_byte;

    assign idx = apb_req_in.paddr[7:2];
    assign wr_en = apb_req_in.psel && apb_req_in.penable && apb_req_in.pwrite && mapped;
    assign wr_on = apb_req_in.pwdata[`TIO_DLY_ON_LSB +: 10];
    assign wr_off = apb_req_in.pwdata[`TIO_DLY_OFF_LSB +: 10];
    assign wr_byte = apb_req_in.pwdata[7:0];
    // Zero wait states: read data is captured in the setup cycle.
    assign pready_out = 1'b1;
    assign pslverr_out = apb_req_in.psel && apb_req_in.penable && !mapped;

    always_comb
    begin
        mapped = 1'b1;
        rd_next = 32'h0000_0000;
        if (idx >= `TIO_IDX_DELAY0 && idx < `TIO_IDX_DELAY0 + 6'(TIO_NUM_OUT))
        begin
            rd_next[`TIO_DLY_ON_LSB +: 10] = delay_reg[3'(idx - `TIO_IDX_DELAY0)].on_dly;
            rd_next[`TIO_DLY_OFF_LSB +: 10] = delay_reg[3'(idx - `TIO_IDX_DELAY0)].off_dly;
        end
        else if (idx >= `TIO_IDX_LOGIC0 && idx < `TIO_IDX_LOGIC0 + 6'(TIO_NUM_LOG))
        begin
            rd_next[`TIO_SEL1_LSB +: 5] = logic_cfg_reg[3'(idx - `TIO_IDX_LOGIC0)].sel1;
            rd_next[`TIO_SEL2_LSB +: 5] = logic_cfg_reg[3'(idx - `TIO_IDX_LOGIC0)].sel2;
            rd_next[`TIO_OP_LSB +: 2] = logic_cfg_reg[3'(idx - `TIO_IDX_LOGIC0)].op;
        end
        else if (idx >= `TIO_IDX_FILT0 && idx < `TIO_IDX_FILT0 + 6'(TIO_NUM_IN))
            rd_next[7:0] = filt_time_reg[4'(idx - `TIO_IDX_FILT0)];
        else if (idx == `TIO_IDX_SETTLE)
            rd_next[7:0] = settle_time_reg;
        else if (idx == `TIO_IDX_STATUS)
        begin
            rd_next[`TIO_ST_IN_LSB +: TIO_NUM_IN] = terminal_filtered_out;
            rd_next[`TIO_ST_OUT_LSB +: TIO_NUM_OUT] = terminal_drive_out;
            rd_next[`TIO_ST_LOG_LSB +: TIO_NUM_LOG] = combined_logic_out;
        end
        else if (idx == `TIO_IDX_STEP)
            rd_next[7:0] = multistep_select_out;
        else
            mapped = 1'b0;
    end

    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
            prdata_out <= 32'h0000_0000;
        else if (apb_req_in.psel && !apb_req_in.penable)
            prdata_out <= rd_next;
    end

    // Out-of-range delay, filter and settle times are clamped to the top of their range.
    generate
        for (genvar d = 0; d < TIO_NUM_OUT; d++)
        begin : g_dly_reg
            always_ff @(posedge clk_in)
            begin
                if (!reset_n_in)
                begin
                    delay_reg[d].on_dly <= `TIO_DELAY_RST;
                    delay_reg[d].off_dly <= `TIO_DELAY_RST;
                end
                else if (wr_en && idx == `TIO_IDX_DELAY0 + 6'(d))
                begin
                    delay_reg[d].on_dly <= (wr_on > `TIO_DELAY_MAX) ? `TIO_DELAY_MAX : wr_on;
                    delay_reg[d].off_dly <= (wr_off > `TIO_DELAY_MAX) ? `TIO_DELAY_MAX : wr_off;
                end
            end
        end
        for (genvar l = 0; l < TIO_NUM_LOG; l++)
        begin : g_log_reg
            always_ff @(posedge clk_in)
            begin
                if (!reset_n_in)
                begin
                    logic_cfg_reg[l].sel1 <= `TIO_SEL_RST;
                    logic_cfg_reg[l].sel2 <= `TIO_SEL_RST;
                    logic_cfg_reg[l].op <= tio_op_t'(`TIO_OP_RST);
                end
                else if (wr_en && idx == `TIO_IDX_LOGIC0 + 6'(l))
                begin
                    logic_cfg_reg[l].sel1 <= apb_req_in.pwdata[`TIO_SEL1_LSB +: 5];
                    logic_cfg_reg[l].sel2 <= apb_req_in.pwdata[`TIO_SEL2_LSB +: 5];
                    // An undefined operator code leaves the operator unchanged.
                    if (apb_req_in.pwdata[`TIO_OP_LSB +: 2] != 2'h3)
                        logic_cfg_reg[l].op <= tio_op_t'(apb_req_in.pwdata[`TIO_OP_LSB +: 2]);
                end
            end
        end
        for (genvar f = 0; f < TIO_NUM_IN; f++)
        begin : g_filt_reg
            always_ff @(posedge clk_in)
            begin
                if (!reset_n_in)
                    filt_time_reg[f] <= `TIO_FILT_RST;
                else if (wr_en && idx == `TIO_IDX_FILT0 + 6'(f))
                    filt_time_reg[f] <= (wr_byte > `TIO_FILT_MAX) ? `TIO_FILT_MAX : wr_byte;
            end
        end
    endgenerate

    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
            settle_time_reg <= `TIO_SETTLE_RST;
        else if (wr_en && idx == `TIO_IDX_SETTLE)
            settle_time_reg <= (wr_byte > `TIO_SETTLE_MAX) ? `TIO_SETTLE_MAX : wr_byte;
    end

    // ****************************************************************
    // Output delays
    // ****************************************************************
    // A tenth of a second is a fixed count of base ticks, counted per output.
    generate
        for (genvar o = 0; o < TIO_NUM_OUT; o++)
        begin : g_out
            logic [15:0] dly_cnt_reg, dly_limit;
            assign dly_limit = 16'(out_source_in[o] ? delay_reg[o].on_dly : delay_reg[o].off_dly)
                * 16'(`TIO_DELAY_TICKS);
            always_ff @(posedge clk_in)
            begin
                if (!reset_n_in)
                begin
                    dly_cnt_reg <= 16'h0000;
                    terminal_drive_out[o] <= 1'b0;
                end
                else if (out_source_in[o] == terminal_drive_out[o])
                    dly_cnt_reg <= 16'h0000;
                else if (dly_cnt_reg >= dly_limit)
                begin
                    terminal_drive_out[o] <= out_source_in[o];
                    dly_cnt_reg <= 16'h0000;
                end
                else if (tick_base)
                    dly_cnt_reg <= dly_cnt_reg + 16'h0001;
            end
        end
    endgenerate

    // ****************************************************************
    // Combined logic outputs
    // ****************************************************************
    // Sources come only from status_source_in, which never carries these outputs.
    generate
        for (genvar c = 0; c < TIO_NUM_LOG; c++)
        begin : g_log
            logic src_a;
            logic src_b;
            assign src_a = status_source_in[logic_cfg_reg[c].sel1];
            assign src_b = status_source_in[logic_cfg_reg[c].sel2];
            always_ff @(posedge clk_in)
            begin
                if (!reset_n_in)
                    combined_logic_out[c] <= 1'b0;
                else
                begin
                    unique case (logic_cfg_reg[c].op)
                        TIO_OP_AND: combined_logic_out[c] <= src_a & src_b;
                        TIO_OP_OR: combined_logic_out[c] <= src_a | src_b;
                        TIO_OP_XOR: combined_logic_out[c] <= src_a ^ src_b;
                        default: combined_logic_out[c] <= src_a & src_b;
                    endcase
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Input filters
    // ****************************************************************
    generate
        for (genvar i = 0; i < TIO_NUM_IN; i++)
        begin : g_in
            logic [2:0] sync_reg;
            logic [7:0] filt_cnt_reg;
            logic stable;
            always_ff @(posedge clk_in)
            begin
                if (!reset_n_in)
                    sync_reg <= 3'h0;
                else
                    sync_reg <= {sync_reg[1:0], terminal_raw_in[i]};
            end
            assign stable = (sync_reg[1] == sync_reg[2]);
            always_ff @(posedge clk_in)
            begin
                if (!reset_n_in)
                begin
                    filt_cnt_reg <= 8'h00;
                    terminal_filtered_out[i] <= 1'b0;
                end
                else if (!stable || sync_reg[2] == terminal_filtered_out[i])
                    filt_cnt_reg <= 8'h00;
                else if (filt_cnt_reg >= filt_time_reg[i])
                begin
                    terminal_filtered_out[i] <= sync_reg[2];
                    filt_cnt_reg <= 8'h00;
                end
                else if (tick_base)
                    filt_cnt_reg <= filt_cnt_reg + 8'h01;
            end
        end
    endgenerate

    // ****************************************************************
    // Multi-step selection settling
    // ****************************************************************
    logic [7:0] step_seen_reg;
    logic [9:0] settle_cnt_reg, settle_limit;
    assign settle_limit = 10'(settle_time_reg) * 10'(`TIO_SETTLE_TICKS);

    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            settle_cnt_reg <= 10'h000;
            step_seen_reg <= 8'h00;
            multistep_select_out <= 8'h00;
        end
        else if (terminal_filtered_out[7:0] != step_seen_reg)
        begin
            step_seen_reg <= terminal_filtered_out[7:0];
            settle_cnt_reg <= 10'h000;
        end
        else if (step_seen_reg != multistep_select_out)
        begin
            if (settle_cnt_reg >= settle_limit)
                multistep_select_out <= step_seen_reg;
            else if (tick_base)
                settle_cnt_reg <= settle_cnt_reg + 10'h001;
        end
    end
endmodule // tio_top

// *** core/tio_cfg.svh ***
`ifndef TIO_CFG_SVH
`define TIO_CFG_SVH

// Clock and time base.
`define TIO_CLK_PERIOD_NS 4
`define TIO_BASE_TICK_NS 2000000
`define TIO_BASE_TICK_CYCLES (`TIO_BASE_TICK_NS / `TIO_CLK_PERIOD_NS)
`define TIO_SETTLE_UNIT_MS 10
`define TIO_DELAY_UNIT_MS 100
`define TIO_INPUT_UNIT_MS 2
`define TIO_SETTLE_TICKS (`TIO_SETTLE_UNIT_MS / `TIO_INPUT_UNIT_MS)
`define TIO_DELAY_TICKS (`TIO_DELAY_UNIT_MS / `TIO_INPUT_UNIT_MS)

// Setting ranges and reset values.
`define TIO_DELAY_MAX 10'h3e8
`define TIO_DELAY_RST 10'h000
`define TIO_FILT_MAX 8'hc8
`define TIO_FILT_RST 8'h01
`define TIO_SETTLE_MAX 8'hc8
`define TIO_SETTLE_RST 8'h00
`define TIO_SEL_RST 5'h00
`define TIO_OP_RST 2'h0

// Word indices of the register map (byte address is four times the index).
`define TIO_IDX_DELAY0 6'h00
`define TIO_IDX_LOGIC0 6'h08
`define TIO_IDX_FILT0 6'h10
`define TIO_IDX_SETTLE 6'h19
`define TIO_IDX_STATUS 6'h1a
`define TIO_IDX_STEP 6'h1b

// Field positions.
`define TIO_DLY_ON_LSB 0
`define TIO_DLY_OFF_LSB 16
`define TIO_SEL1_LSB 0
`define TIO_SEL2_LSB 8
`define TIO_OP_LSB 16
`define TIO_ST_IN_LSB 0
`define TIO_ST_OUT_LSB 9
`define TIO_ST_LOG_LSB 15

`endif

// *** core/tio_pkg.sv ***
package tio_pkg;

    localparam int TIO_NUM_OUT = 6;
    localparam int TIO_NUM_LOG = 6;
    localparam int TIO_NUM_IN = 9;
    localparam int TIO_NUM_SRC = 32;

    typedef enum logic [1:0] {
        TIO_OP_AND = 2'h0,
        TIO_OP_OR = 2'h1,
        TIO_OP_XOR = 2'h2
    } tio_op_t;

    typedef struct packed {
        logic [9:0] off_dly;
        logic [9:0] on_dly;
    } tio_delay_t;

    typedef struct packed {
        tio_op_t op;
        logic [4:0] sel2;
        logic [4:0] sel1;
    } tio_logic_cfg_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } tio_apb_req_t;

endpackage

// *** bench/tio_monitor.sv ***
`timescale 1ns/1ns
// ******
// Port checker.
// ******
module tio_monitor #(
    parameter int TICK_CYCLES = 10
) (
    // Clock, reset and bus.
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire tio_pkg::tio_apb_req_t apb_req_in,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic [31:0] prdata_out,
    // Terminals.
    input wire logic [8:0] terminal_raw_in,
    input wire logic [5:0] out_source_in,
    input wire logic [31:0] status_source_in,
    input wire logic [8:0] terminal_filtered_out,
    input wire logic [5:0] terminal_drive_out,
    input wire logic [5:0] combined_logic_out,
    input wire logic [7:0] multistep_select_out
);
    import tio_pkg::*;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);
    logic acc;
    logic wr;
    logic hit;
    logic [5:0] idx;
    assign acc = apb_req_in.psel && apb_req_in.penable;
    assign wr = acc && apb_req_in.pwrite;
    assign idx = apb_req_in.paddr[7:2];
    // Word holes at 6, 7, 14 and 15 answer as unmapped.
    assign hit = idx < 6'h1c && idx != 6'h06 && idx != 6'h07 && idx != 6'h0e && idx != 6'h0f;
    sequence s_rd_status;
        apb_req_in.psel && !apb_req_in.penable && !apb_req_in.pwrite && apb_req_in.paddr == 8'h68 ##1 acc;
    endsequence
    property p_ready;
        pready_out;
    endproperty
    property p_slverr;
        acc |-> pslverr_out == !hit;
    endproperty
    property p_hole_zero;
        acc && !hit |-> prdata_out == 32'h0;
    endproperty
    property p_status;
        s_rd_status |-> prdata_out[20:0] == $past({combined_logic_out, terminal_drive_out, terminal_filtered_out});
    endproperty
    // An output may only move towards what its source showed one or two cycles before.
    property p_drive;
        ((terminal_drive_out ^ $past(terminal_drive_out)) & (terminal_drive_out ^ $past(out_source_in))
            & (terminal_drive_out ^ $past(out_source_in, 2))) == 6'h0;
    endproperty
    property p_filter;
        ((terminal_filtered_out ^ $past(terminal_filtered_out))
            & (terminal_filtered_out ^ $past(terminal_raw_in, 3))) == 9'h0;
    endproperty
    property p_step;
        $changed(multistep_select_out) |-> multistep_select_out == $past(terminal_filtered_out[7:0]);
    endproperty
    property p_logic;
        $changed(combined_logic_out) |-> $past(status_source_in) != $past(status_source_in, 2)
            || $past(wr) || $past(wr, 2) || !$past(reset_n_in, 2) || !$past(reset_n_in, 3);
    endproperty
    a_ready: assert property (p_ready) else $error("pready low");
    a_slverr: assert property (p_slverr) else $error("pslverr wrong");
    a_hole_zero: assert property (p_hole_zero) else $error("hole read not zero");
    a_status: assert property (p_status) else $error("status read wrong");
    a_drive: assert property (p_drive) else $error("drive moved without source");
    a_filter: assert property (p_filter) else $error("filter took unheld level");
    a_step: assert property (p_step) else $error("step latch wrong");
    a_logic: assert property (p_logic) else $error("logic moved without cause");
endmodule // tio_monitor

bind tio_top tio_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_mon (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .apb_req_in(apb_req_in), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .prdata_out(prdata_out), .terminal_raw_in(terminal_raw_in),
    .out_source_in(out_source_in), .status_source_in(status_source_in),
    .terminal_filtered_out(terminal_filtered_out), .terminal_drive_out(terminal_drive_out),
    .combined_logic_out(combined_logic_out), .multistep_select_out(multistep_select_out)
);

// *** bench/tio_field_model.sv ***
`timescale 1ns/1ns
module tio_field_model (
    // Commanded levels and bounce.
    input wire logic [8:0] level_in,
    input wire logic [8:0] glitch_in,
    // Pins.
    output logic [8:0] raw_out
);
    // Bounce inverts a pin only while commanded, so faults stay under bench control.
    assign raw_out = level_in ^ glitch_in;
endmodule // tio_field_model

// *** bench/terminal_io_timing_logic_bench.sv ***
`timescale 1ns/1ns
module terminal_io_timing_logic_bench;
    import tio_pkg::*;
    logic clk_in;
    logic reset_n_in;
    tio_apb_req_t req;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [8:0] level;
    logic [8:0] glitch;
    logic [8:0] raw;
    logic [5:0] src;
    logic [31:0] stat;
    logic [8:0] filt;
    logic [5:0] drv;
    logic [5:0] lgc;
    logic [7:0] ms;
    logic [31:0] got_q;
    logic got_e;
    int bad_count = 0;
    int total_checks = 0;

    tio_top #(.TICK_CYCLES(10)) dut (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .apb_req_in(req), .pready_out(pready),
        .pslverr_out(pslverr), .prdata_out(prdata), .terminal_raw_in(raw), .out_source_in(src),
        .status_source_in(stat), .terminal_filtered_out(filt), .terminal_drive_out(drv),
        .combined_logic_out(lgc), .multistep_select_out(ms)
    );
    tio_field_model field (.level_in(level), .glitch_in(glitch), .raw_out(raw));

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic stall();
        bad_count++;
        $display("wait ran out");
        wrap_up();
    endtask

    // One whole transfer, then one idle edge so the next setup never lands in the same step.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk_in);
        req.penable <= 1'b1;
        for (n = 0; n < 20; n++)
        begin
            @(posedge clk_in);
            if (pready === 1'b1)
                break;
        end
        if (n == 20)
            stall();
        got_q = prdata;
        got_e = pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        @(posedge clk_in);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check($sformatf("reg %h", a), exp, got_q);
    endtask

    task automatic wait_bit(input int sel, input int idx, input logic v, input int lim, output int t);
        logic [31:0] w;
        for (t = 1; t <= lim; t++)
        begin
            @(posedge clk_in);
            w = sel == 0 ? 32'(drv) : sel == 1 ? 32'(filt) : 32'(ms);
            if (w[idx] === v)
                break;
        end
        if (t > lim)
            stall();
    endtask

    task automatic t_regs();
        int i;
        for (i = 0; i < 6; i++)
        begin
            rd(8'(i * 4), 32'h0);
            rd(8'(32 + i * 4), 32'h0);
        end
        for (i = 0; i < 9; i++)
            rd(8'(64 + i * 4), 32'h1);
        rd(8'h64, 32'h0);
        rd(8'h70, 32'h0);
        check("slverr", 32'h1, 32'(got_e));
        apb(1'b1, 8'h00, 32'h03ff_03ff);
        rd(8'h00, 32'h03e8_03e8);
        apb(1'b1, 8'h40, 32'hff);
        rd(8'h40, 32'hc8);
        apb(1'b1, 8'h64, 32'hff);
        rd(8'h64, 32'hc8);
        apb(1'b1, 8'h24, 32'h0003_0102);
        rd(8'h24, 32'h0000_0102);
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b1, 8'h40, 32'h1);
        apb(1'b1, 8'h64, 32'h0);
        $display("register test done");
    endtask

    task automatic t_logic();
        int n;
        int c;
        logic a;
        logic b;
        logic e;
        for (n = 0; n < 6; n++)
        begin
            apb(1'b1, 8'(32 + n * 4), {14'h0, 2'(n % 3), 3'h0, 5'(n + 8), 3'h0, 5'(31 - n)});
            for (c = 0; c < 4; c++)
            begin
                a = c[0];
                b = c[1];
                stat <= (32'(a) << (31 - n)) | (32'(b) << (n + 8));
                repeat (3) @(posedge clk_in);
                e = n % 3 == 0 ? a & b : n % 3 == 1 ? a | b : a ^ b;
                check("logic", 32'(e), 32'(lgc[n]));
            end
        end
        stat <= 32'h0;
        $display("logic test done");
    endtask

    task automatic t_delay();
        int t;
        src <= 6'h20;
        wait_bit(0, 5, 1'b1, 5, t);
        src <= 6'h00;
        wait_bit(0, 5, 1'b0, 5, t);
        apb(1'b1, 8'h00, 32'h0002_0002);
        src <= 6'h01;
        wait_bit(0, 0, 1'b1, 1100, t);
        check("on delay", 32'h1, 32'(t >= 985));
        src <= 6'h00;
        repeat (900) @(posedge clk_in);
        check("off early", 32'h1, 32'(drv[0]));
        src <= 6'h01;
        repeat (800) @(posedge clk_in);
        check("off cancel", 32'h1, 32'(drv[0]));
        src <= 6'h00;
        wait_bit(0, 0, 1'b0, 1100, t);
        check("off delay", 32'h1, 32'(t >= 985));
        apb(1'b1, 8'h00, 32'h0);
        $display("delay test done");
    endtask

    task automatic filt_case(input int idx, input int ticks);
        int t;
        apb(1'b1, 8'(64 + idx * 4), 32'(ticks));
        level[idx] <= 1'b1;
        wait_bit(1, idx, 1'b1, ticks * 10 + 20, t);
        check("filter hold", 32'h1, 32'(t + 10 >= ticks * 10));
        if (ticks > 1)
        begin
            glitch[idx] <= 1'b1;
            repeat (5) @(posedge clk_in);
            glitch[idx] <= 1'b0;
            repeat (40) @(posedge clk_in);
            check("filter glitch", 32'h1, 32'(filt[idx]));
        end
        level[idx] <= 1'b0;
        wait_bit(1, idx, 1'b0, ticks * 10 + 20, t);
        apb(1'b1, 8'(64 + idx * 4), 32'h1);
    endtask

    task automatic t_step();
        int t;
        apb(1'b1, 8'h64, 32'h2);
        level[7:0] <= 8'ha5;
        wait_bit(1, 0, 1'b1, 40, t);
        wait_bit(2, 0, 1'b1, 150, t);
        check("settle min", 32'h1, 32'(t >= 85));
        check("step", 32'ha5, 32'(ms));
        rd(8'h6c, 32'ha5);
        rd(8'h68, 32'ha5);
        apb(1'b1, 8'h64, 32'h0);
        level <= 9'h0;
        wait_bit(2, 0, 1'b0, 40, t);
        $display("step test done");
    endtask

    initial
    begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end

    initial
    begin
        reset_n_in <= 1'b0;
        req <= '0;
        level <= 9'h0;
        glitch <= 9'h0;
        src <= 6'h0;
        stat <= 32'h0;
        repeat (3) @(posedge clk_in);
        reset_n_in <= 1'b1;
        @(posedge clk_in);
        t_regs();
        t_logic();
        t_delay();
        filt_case(2, 3);
        filt_case(3, 0);
        filt_case(4, 200);
        filt_case(8, 2);
        $display("filter test done");
        t_step();
        wrap_up();
    end
endmodule // terminal_io_timing_logic_bench
